// File: hdl/clc_chan_ctrl.sv
// Cursor layer channel control and status register bank
//
// The plain strobed port was chosen for this implementation.
module clc_chan_ctrl
    import clc_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
)
(
    input  wire logic                  clock_i,
    input  wire logic                  srst_i,
    input  wire logic [ADDR_WIDTH-1:0] addr_i,
    input  wire logic [DATA_W-1:0]     wdata_i,
    input  wire logic                  wr_stb_i,
    input  wire logic                  rd_stb_i,
    output logic      [DATA_W-1:0]     rdata_o,
    input  wire logic                  frame_start_i,
    input  wire logic                  frame_end_i,
    input  wire logic                  head_added_i,
    input  wire logic [31:0]           head_reg_i,
    input  wire clc_evt_t              evt_i,
    output clc_ctl_t                   ctl_o,
    output logic                       irq_o
);

    // Address decode helper
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                 input logic [31:0]           ofs);
        hit = (a == ofs[ADDR_WIDTH-1:0]);
    endfunction : hit

    clc_chan_t           chan_q;
    clc_chan_t           chan_d;
    logic                refresh_q;
    logic                queue_q;
    logic [31:0]         head_ptr_q;
    logic                apply_q;
    logic                abort_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rdata_d;
    logic [NUM_SRC-1:0]  mask;
    logic [NUM_SRC-1:0]  flags;
    logic [NUM_SRC-1:0]  irq_bits;

    logic                wr_en_reg;
    logic                wr_dis_reg;
    logic                wr_ien_reg;
    logic                wr_idis_reg;
    logic                rd_isr;
    logic                want_on;
    logic                want_off;
    logic                want_abort;
    logic                want_refresh;
    logic                want_queue;

    assign wr_en_reg    = wr_stb_i && hit(addr_i, OFS_CHAN_ENABLE);
    assign wr_dis_reg   = wr_stb_i && hit(addr_i, OFS_CHAN_DISABLE);
    assign wr_ien_reg   = wr_stb_i && hit(addr_i, OFS_IRQ_ENABLE);
    assign wr_idis_reg  = wr_stb_i && hit(addr_i, OFS_IRQ_DISABLE);
    assign rd_isr       = rd_stb_i && hit(addr_i, OFS_IRQ_STATUS);

    // Zero bits of a command write do nothing
    assign want_on      = wr_en_reg && wdata_i[BIT_CHAN_ON];
    assign want_refresh = wr_en_reg && wdata_i[BIT_ATTR_REFRESH];
    assign want_queue   = wr_en_reg && wdata_i[BIT_HEAD_QUEUE];
    assign want_off     = wr_dis_reg && wdata_i[BIT_CHAN_OFF];
    assign want_abort   = wr_dis_reg && wdata_i[BIT_CHAN_ABORT];

    assign irq_bits = wdata_i[BIT_IRQ_LSB +: NUM_SRC];

    // Channel state: abort beats everything, then disable, then enable
    always_comb begin
        chan_d = chan_q;
        case (chan_q)
            CH_OFF: begin
                if (!want_abort && want_on) begin
                    chan_d = CH_ON;
                end
            end
            CH_ON: begin
                if (want_abort) begin
                    chan_d = CH_OFF;
                end else if (want_off) begin
                    chan_d = CH_STOPPING;
                end
            end
            CH_STOPPING: begin
                if (want_abort || frame_end_i) begin
                    chan_d = CH_OFF;
                end else if (want_on) begin
                    chan_d = CH_ON;
                end
            end
            default: begin
                chan_d = CH_OFF;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            chan_q <= CH_OFF;
        end else begin
            chan_q <= chan_d;
        end
    end

    // One-cycle layer reset pulse on abort
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= want_abort;
        end
    end

    // Attribute refresh pending until frame start, new request wins
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            refresh_q <= 1'b0;
        end else if (want_refresh) begin
            refresh_q <= 1'b1;
        end else if (want_abort || frame_start_i) begin
            refresh_q <= 1'b0;
        end
    end

    // Apply pulse at the frame start that consumes the request
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            apply_q <= 1'b0;
        end else begin
            apply_q <= refresh_q && frame_start_i && !want_abort;
        end
    end

    // Head queue request held until the fetcher adds it
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            queue_q <= 1'b0;
        end else if (want_queue) begin
            queue_q <= 1'b1;
        end else if (want_abort || head_added_i) begin
            queue_q <= 1'b0;
        end
    end

    // Head address captured with the queue request
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            head_ptr_q <= RST_HEAD_PTR;
        end else if (want_queue) begin
            head_ptr_q <= head_reg_i;
        end
    end

    clc_irq_flags i_clc_irq_flags (
        .clock_i  (clock_i),
        .srst_i   (srst_i),
        .evt_i    (evt_i),
        .en_wr_i  (wr_ien_reg),
        .dis_wr_i (wr_idis_reg),
        .clr_i    (rd_isr),
        .wbits_i  (irq_bits),
        .mask_o   (mask),
        .flags_o  (flags),
        .irq_o    (irq_o)
    );

    // Read mux; write-only and unmapped addresses read zero
    always_comb begin
        rdata_d = RD_ZERO;
        if (rd_stb_i) begin
            if (hit(addr_i, OFS_CHAN_STATUS)) begin
                rdata_d[BIT_CHAN_ON]      = (chan_q != CH_OFF);
                rdata_d[BIT_ATTR_REFRESH] = refresh_q;
                rdata_d[BIT_HEAD_QUEUE]   = queue_q;
            end else if (hit(addr_i, OFS_IRQ_MASK)) begin
                rdata_d[BIT_IRQ_LSB +: NUM_SRC] = mask;
            end else if (hit(addr_i, OFS_IRQ_STATUS)) begin
                rdata_d[BIT_IRQ_LSB +: NUM_SRC] = flags;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_q <= RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o              = rdata_q;
    assign ctl_o.chan_enable    = (chan_q != CH_OFF);
    assign ctl_o.layer_reset    = abort_q;
    assign ctl_o.attr_apply     = apply_q;
    assign ctl_o.head_queue_req = queue_q;
    assign ctl_o.head_ptr       = head_ptr_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    sequence s_turn_on;
        want_on && !want_abort && !want_off;
    endsequence

    sequence s_stop_req;
        chan_q == CH_ON && want_off && !want_abort;
    endsequence

    sequence s_abort_wr;
        want_abort && !want_refresh && !want_queue;
    endsequence

    sequence s_status_rd;
        rd_stb_i && hit(addr_i, OFS_CHAN_STATUS);
    endsequence

    chk_chan_turn_on: assert property (
        s_turn_on |=> ctl_o.chan_enable)
        else $error("enable write did not turn channel on");
    chk_stop_waits_frame: assert property (
        s_stop_req ##1 (!frame_end_i && !want_abort)
        |-> ctl_o.chan_enable ##1 ctl_o.chan_enable)
        else $error("channel stopped before frame end");
    chk_stop_at_end: assert property (
        chan_q == CH_STOPPING && frame_end_i |=> !ctl_o.chan_enable)
        else $error("channel still on after frame end");
    chk_abort_now: assert property (
        want_abort |=> !ctl_o.chan_enable && ctl_o.layer_reset
                       && !ctl_o.head_queue_req)
        else $error("abort did not reset the layer");
    chk_refresh_apply: assert property (
        refresh_q && frame_start_i && !want_refresh && !want_abort
        |=> ctl_o.attr_apply && !refresh_q)
        else $error("attribute refresh not applied at frame start");
    chk_refresh_status: assert property (
        want_refresh ##1 rd_stb_i && hit(addr_i, OFS_CHAN_STATUS)
        |=> rdata_o[BIT_ATTR_REFRESH])
        else $error("refresh pending not reported");
    chk_queue_clear: assert property (
        queue_q && head_added_i && !want_queue |=> !ctl_o.head_queue_req)
        else $error("queue request not cleared when head added");
    chk_queue_pending: assert property (
        want_queue |=> ctl_o.head_queue_req
                       && ctl_o.head_ptr == $past(head_reg_i))
        else $error("queue request or head address not held");
    chk_wo_read_zero: assert property (
        rd_stb_i && (hit(addr_i, OFS_CHAN_ENABLE)
                     || hit(addr_i, OFS_IRQ_DISABLE)) |=> rdata_o == RD_ZERO)
        else $error("write-only register read not zero");
    chk_rdata_one_cycle: assert property (
        !rd_stb_i |=> rdata_o == RD_ZERO)
        else $error("read data outside read answer");

    // Channel state
    chk_zero_enable_nop: assert property (
        chan_q == CH_OFF && !want_on |=> !ctl_o.chan_enable)
        else $error("channel turned on without an enable write");
    chk_stop_resume: assert property (
        chan_q == CH_STOPPING && want_on && !frame_end_i && !want_abort
        |=> chan_q == CH_ON)
        else $error("enable during stop did not resume channel");
    chk_off_ignores_stop: assert property (
        chan_q == CH_OFF && want_off |=> chan_q == CH_OFF)
        else $error("disable while off changed the channel");
    chk_abort_stopping: assert property (
        chan_q == CH_STOPPING && want_abort |=> !ctl_o.chan_enable)
        else $error("abort while stopping did not turn off");
    chk_reset_pulse_len: assert property (
        !want_abort |=> !ctl_o.layer_reset)
        else $error("layer reset without an abort write");
    chk_abort_clears: assert property (
        s_abort_wr |=> !refresh_q && !ctl_o.attr_apply)
        else $error("abort left attribute refresh pending");

    // Pending requests
    chk_apply_needs_frame: assert property (
        !(refresh_q && frame_start_i) |=> !ctl_o.attr_apply)
        else $error("attribute apply outside a pending frame start");
    chk_refresh_holds: assert property (
        refresh_q && !frame_start_i && !want_abort |=> refresh_q)
        else $error("refresh pending dropped early");
    chk_queue_holds: assert property (
        queue_q && !head_added_i && !want_abort |=> ctl_o.head_queue_req)
        else $error("queue request dropped before head added");
    chk_zero_queue_nop: assert property (
        !queue_q && !want_queue |=> !ctl_o.head_queue_req)
        else $error("queue request without a queue write");
    chk_head_ptr_hold: assert property (
        !want_queue |=> $stable(ctl_o.head_ptr))
        else $error("head address changed without a queue write");

    // Read answers
    chk_status_read: assert property (
        s_status_rd |=> rdata_o[BIT_CHAN_ON] == $past(ctl_o.chan_enable)
            && rdata_o[BIT_ATTR_REFRESH] == $past(refresh_q)
            && rdata_o[BIT_HEAD_QUEUE] == $past(queue_q))
        else $error("channel status read does not match state");
    chk_mask_read: assert property (
        rd_stb_i && hit(addr_i, OFS_IRQ_MASK)
        |=> rdata_o[BIT_IRQ_LSB +: NUM_SRC] == $past(mask))
        else $error("mask read does not match mask");
    chk_flags_read: assert property (
        rd_isr |=> rdata_o[BIT_IRQ_LSB +: NUM_SRC] == $past(flags))
        else $error("status read does not match flags");
    chk_read_clears: assert property (
        rd_isr && evt_i == '0 |=> flags == '0)
        else $error("status read did not clear flags");
    chk_event_in_read: assert property (
        rd_isr && evt_i.overflow |=> flags[NUM_SRC-1])
        else $error("event lost in clearing read");
    chk_wo_other_zero: assert property (
        rd_stb_i && (hit(addr_i, OFS_CHAN_DISABLE)
                     || hit(addr_i, OFS_IRQ_ENABLE)) |=> rdata_o == RD_ZERO)
        else $error("write-only register read not zero");
    chk_irq_idle: assert property (
        flags == '0 |-> !irq_o)
        else $error("interrupt without a pending flag");

endmodule : clc_chan_ctrl

// File: hdl/clc_pkg.sv
// Constants and carrier types of the cursor layer channel control block
package clc_pkg;

    localparam int          ADDR_W          = 32;
    localparam int          DATA_W          = 32;
    localparam int          NUM_SRC         = 5;

    // Register byte addresses
    localparam logic [31:0] OFS_CHAN_ENABLE  = 32'hf803_8340;
    localparam logic [31:0] OFS_CHAN_DISABLE = 32'hf803_8344;
    localparam logic [31:0] OFS_CHAN_STATUS  = 32'hf803_8348;
    localparam logic [31:0] OFS_IRQ_ENABLE   = 32'hf803_834c;
    localparam logic [31:0] OFS_IRQ_DISABLE  = 32'hf803_8350;
    localparam logic [31:0] OFS_IRQ_MASK     = 32'hf803_8354;
    localparam logic [31:0] OFS_IRQ_STATUS   = 32'hf803_8358;

    // Channel enable and status field positions
    localparam int          BIT_CHAN_ON      = 0;
    localparam int          BIT_ATTR_REFRESH = 1;
    localparam int          BIT_HEAD_QUEUE   = 2;
    // Channel disable field positions
    localparam int          BIT_CHAN_OFF     = 0;
    localparam int          BIT_CHAN_ABORT   = 8;
    // Interrupt source field: bits 2 to 6
    localparam int          BIT_IRQ_LSB      = 2;

    // Reset values
    localparam logic [4:0]  RST_IRQ_MASK     = 5'h0_0;
    localparam logic [4:0]  RST_IRQ_FLAGS    = 5'h0_0;
    localparam logic [31:0] RST_HEAD_PTR     = 32'h0000_0000;
    localparam logic [31:0] RD_ZERO          = 32'h0000_0000;

    // Interrupt sources in field order, lsb is transfer end
    typedef struct packed {
        logic overflow;
        logic end_of_list;
        logic head_loaded;
        logic desc_loaded;
        logic transfer_end;
    } clc_evt_t;

    // Controls driven to the layer DMA
    typedef struct packed {
        logic        chan_enable;
        logic        layer_reset;
        logic        attr_apply;
        logic        head_queue_req;
        logic [31:0] head_ptr;
    } clc_ctl_t;

    typedef enum logic [2:0] {
        CH_OFF      = 3'b001,
        CH_ON       = 3'b010,
        CH_STOPPING = 3'b100
    } clc_chan_t;

endpackage : clc_pkg

// File: hdl/clc_irq_flags.sv
// Interrupt mask, sticky clear-on-read flags and interrupt output
module clc_irq_flags
    import clc_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 srst_i,
    input  wire clc_evt_t             evt_i,
    input  wire logic                 en_wr_i,
    input  wire logic                 dis_wr_i,
    input  wire logic                 clr_i,
    input  wire logic [NUM_SRC-1:0]   wbits_i,
    output logic      [NUM_SRC-1:0]   mask_o,
    output logic      [NUM_SRC-1:0]   flags_o,
    output logic                      irq_o
);

    logic [NUM_SRC-1:0] mask_q;
    logic [NUM_SRC-1:0] flags_q;
    logic [NUM_SRC-1:0] evt_bits;

    assign evt_bits = evt_i;

    // Mask accumulates enable and disable writes
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            mask_q <= RST_IRQ_MASK;
        end else if (en_wr_i) begin
            mask_q <= mask_q | wbits_i;
        end else if (dis_wr_i) begin
            mask_q <= mask_q & ~wbits_i;
        end
    end

    // Sticky flags, event wins over read clear
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            flags_q <= RST_IRQ_FLAGS;
        end else if (clr_i) begin
            flags_q <= evt_bits;
        end else begin
            flags_q <= flags_q | evt_bits;
        end
    end

    assign mask_o  = mask_q;
    assign flags_o = flags_q;
    assign irq_o   = |(flags_q & mask_q);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    chk_flag_set_wins: assert property (
        evt_i.transfer_end |=> flags_o[0])
        else $error("transfer end event lost");
    chk_flag_read_clear: assert property (
        clr_i && !evt_i.overflow |=> !flags_o[4])
        else $error("overflow flag not cleared by read");
    chk_mask_enable: assert property (
        en_wr_i && wbits_i[3] |=> mask_o[3])
        else $error("enable write did not set mask");
    chk_mask_disable: assert property (
        dis_wr_i && !en_wr_i && wbits_i[1] |=> !mask_o[1])
        else $error("disable write did not clear mask");
    chk_mask_hold: assert property (
        !en_wr_i && !dis_wr_i |=> mask_o == $past(mask_o))
        else $error("mask changed without a write");
    chk_irq_level: assert property (
        (flags_o[2] && mask_o[2]) |-> irq_o)
        else $error("enabled pending source without interrupt");

endmodule : clc_irq_flags

// File: dv/clc_chan_ctrl_bench.sv
// Self-checking bench for the cursor layer channel control block
module clc_chan_ctrl_bench;
    import clc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_i;
    logic        srst_i;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic        frame_start;
    logic        frame_end;
    logic        head_added;
    logic [31:0] head_reg;
    clc_evt_t    evt;
    clc_ctl_t    ctl;
    logic        irq;
    int          errors;
    int          compares;

    clc_chan_ctrl i_clc_chan_ctrl (
        .clock_i       (clock_i),
        .srst_i        (srst_i),
        .addr_i        (addr),
        .wdata_i       (wdata),
        .wr_stb_i      (wr_stb),
        .rd_stb_i      (rd_stb),
        .rdata_o       (rdata),
        .frame_start_i (frame_start),
        .frame_end_i   (frame_end),
        .head_added_i  (head_added),
        .head_reg_i    (head_reg),
        .evt_i         (evt),
        .ctl_o         (ctl),
        .irq_o         (irq)
    );

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'h1;
        @(posedge clock_i);
        wr_stb <= 1'h0;
        #1;
    endtask : wr

    task automatic rdchk(input string n, input logic [31:0] a,
                         input logic [31:0] e);
        @(posedge clock_i);
        addr   <= a;
        rd_stb <= 1'h1;
        @(posedge clock_i);
        rd_stb <= 1'h0;
        #1;
        chk(n, e, rdata);
    endtask : rdchk

    // One-cycle pulses on frame inputs {start, end, head added} and events
    task automatic pls(input logic [2:0] f, input clc_evt_t e);
        @(posedge clock_i);
        {frame_start, frame_end, head_added} <= f;
        evt <= e;
        @(posedge clock_i);
        {frame_start, frame_end, head_added} <= 3'h0;
        evt <= '0;
        #1;
    endtask : pls

    task automatic t_reset();
        #1;
        chk("ctl bits", 32'h0000_0000, {28'h000_0000, ctl.chan_enable,
            ctl.layer_reset, ctl.attr_apply, ctl.head_queue_req});
        chk("irq", 32'h0000_0000, {31'h0, irq});
        rdchk("chan status", OFS_CHAN_STATUS, 32'h0000_0000);
        rdchk("irq mask", OFS_IRQ_MASK, 32'h0000_0000);
        rdchk("irq status", OFS_IRQ_STATUS, 32'h0000_0000);
        rdchk("rd enable", OFS_CHAN_ENABLE, 32'h0000_0000);
        rdchk("rd disable", OFS_CHAN_DISABLE, 32'h0000_0000);
        rdchk("rd irq en", OFS_IRQ_ENABLE, 32'h0000_0000);
        rdchk("rd irq dis", OFS_IRQ_DISABLE, 32'h0000_0000);
        rdchk("unmapped", 32'hf803_835c, 32'h0000_0000);
    endtask : t_reset

    task automatic t_chan();
        wr(OFS_CHAN_ENABLE, 32'h0000_0000);
        chk("enable zero", 32'h0000_0000, {31'h0, ctl.chan_enable});
        wr(OFS_CHAN_ENABLE, 32'h0000_0001);
        chk("enable one", 32'h0000_0001, {31'h0, ctl.chan_enable});
        rdchk("status on", OFS_CHAN_STATUS, 32'h0000_0001);
        wr(OFS_CHAN_DISABLE, 32'h0000_0001);
        chk("stopping", 32'h0000_0001, {31'h0, ctl.chan_enable});
        rdchk("status stop", OFS_CHAN_STATUS, 32'h0000_0001);
        wr(OFS_CHAN_ENABLE, 32'h0000_0001);
        pls(3'h2, '0);
        chk("resume on", 32'h0000_0001, {31'h0, ctl.chan_enable});
        wr(OFS_CHAN_DISABLE, 32'h0000_0001);
        pls(3'h2, '0);
        chk("frame end", 32'h0000_0000, {31'h0, ctl.chan_enable});
        rdchk("status off", OFS_CHAN_STATUS, 32'h0000_0000);
    endtask : t_chan

    task automatic t_abort();
        head_reg <= 32'h1000_0040;
        wr(OFS_CHAN_ENABLE, 32'h0000_0007);
        rdchk("status all", OFS_CHAN_STATUS, 32'h0000_0007);
        wr(OFS_CHAN_DISABLE, 32'h0000_0100);
        chk("reset pulse", 32'h0000_0001, {31'h0, ctl.layer_reset});
        chk("abort off", 32'h0000_0000, {31'h0, ctl.chan_enable});
        @(posedge clock_i);
        #1;
        chk("reset end", 32'h0000_0000, {31'h0, ctl.layer_reset});
        rdchk("abort status", OFS_CHAN_STATUS, 32'h0000_0000);
    endtask : t_abort

    task automatic t_refresh();
        wr(OFS_CHAN_ENABLE, 32'h0000_0002);
        rdchk("refresh pend", OFS_CHAN_STATUS, 32'h0000_0002);
        pls(3'h4, '0);
        chk("attr apply", 32'h0000_0001, {31'h0, ctl.attr_apply});
        rdchk("refresh done", OFS_CHAN_STATUS, 32'h0000_0000);
    endtask : t_refresh

    task automatic t_queue();
        head_reg <= 32'h2000_1230;
        wr(OFS_CHAN_ENABLE, 32'h0000_0004);
        chk("queue req", 32'h0000_0001, {31'h0, ctl.head_queue_req});
        chk("head ptr", 32'h2000_1230, ctl.head_ptr);
        rdchk("queue pend", OFS_CHAN_STATUS, 32'h0000_0004);
        pls(3'h1, '0);
        chk("queue clr", 32'h0000_0000, {31'h0, ctl.head_queue_req});
        rdchk("queue done", OFS_CHAN_STATUS, 32'h0000_0000);
    endtask : t_queue

    task automatic t_irq();
        logic [4:0] m;
        clc_evt_t   ov;
        m = 5'h00;
        wr(OFS_IRQ_ENABLE, 32'h0000_0000);
        rdchk("mask zero", OFS_IRQ_MASK, 32'h0000_0000);
        for (int i = 0; i < NUM_SRC; i++) begin
            wr(OFS_IRQ_ENABLE, 32'h0000_0004 << i);
            m[i] = 1'h1;
            rdchk("mask acc", OFS_IRQ_MASK, {25'h0, m, 2'h0});
            pls(3'h0, clc_evt_t'(5'h01 << i));
            chk("irq set", 32'h0000_0001, {31'h0, irq});
            rdchk("flag", OFS_IRQ_STATUS, 32'h0000_0004 << i);
            rdchk("flag clr", OFS_IRQ_STATUS, 32'h0000_0000);
            chk("irq clr", 32'h0000_0000, {31'h0, irq});
        end
        wr(OFS_IRQ_DISABLE, 32'h0000_0054);
        rdchk("mask dis", OFS_IRQ_MASK, 32'h0000_0028);
        pls(3'h0, clc_evt_t'(5'h15));
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        rdchk("masked flags", OFS_IRQ_STATUS, 32'h0000_0054);
        pls(3'h0, clc_evt_t'(5'h02));
        chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
        rdchk("flag descriptor_loaded_flag", OFS_IRQ_STATUS, 32'h0000_0008);
        ov = '0;
        ov.overflow = 1'h1;
        @(posedge clock_i);
        addr   <= OFS_IRQ_STATUS;
        rd_stb <= 1'h1;
        evt    <= ov;
        @(posedge clock_i);
        rd_stb <= 1'h0;
        evt    <= '0;
        #1;
        chk("race read", 32'h0000_0000, rdata);
        rdchk("race set", OFS_IRQ_STATUS, 32'h0000_0040);
    endtask : t_irq

    task automatic t_midrst();
        wr(OFS_CHAN_ENABLE, 32'h0000_0007);
        pls(3'h0, clc_evt_t'(5'h02));
        chk("pre rst irq", 32'h0000_0001, {31'h0, irq});
        @(posedge clock_i);
        srst_i <= 1'h1;
        @(posedge clock_i);
        srst_i <= 1'h0;
        #1;
        chk("rst ctl", 32'h0000_0000, {28'h000_0000, ctl.chan_enable,
            ctl.layer_reset, ctl.attr_apply, ctl.head_queue_req});
        chk("rst head", RST_HEAD_PTR, ctl.head_ptr);
        chk("rst irq", 32'h0000_0000, {31'h0, irq});
        rdchk("rst status", OFS_CHAN_STATUS, 32'h0000_0000);
        rdchk("rst mask", OFS_IRQ_MASK, 32'h0000_0000);
        rdchk("rst flags", OFS_IRQ_STATUS, 32'h0000_0000);
    endtask : t_midrst

    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        srst_i      = 1'h1;
        addr        = 32'h0000_0000;
        wdata       = 32'h0000_0000;
        wr_stb      = 1'h0;
        rd_stb      = 1'h0;
        frame_start = 1'h0;
        frame_end   = 1'h0;
        head_added  = 1'h0;
        head_reg    = 32'h0000_0000;
        evt         = '0;
        errors      = 0;
        compares    = 0;
        repeat (3) @(posedge clock_i);
        srst_i <= 1'h0;
        t_reset();
        t_chan();
        t_abort();
        t_refresh();
        t_queue();
        t_irq();
        t_midrst();
        report_and_stop();
    end

    initial begin
        repeat (2000) @(posedge clock_i);
        errors++;
        report_and_stop();
    end

endmodule : clc_chan_ctrl_bench
